// *** verilog/pim_pkg.sv ***
// constants and carrier types for the process image block
package pim_pkg;
   localparam logic [15:0] PIM_IDX_OUT_MAP = 16'h1600;
   localparam logic [15:0] PIM_IDX_IN_MAP = 16'h1A00;
   localparam logic [15:0] PIM_IDX_ST_MAP = 16'h1A01;
   localparam logic [15:0] PIM_IDX_DIN = 16'h4000;
   localparam logic [15:0] PIM_IDX_FLT = 16'h4001;
   localparam logic [15:0] PIM_IDX_DOUT = 16'h5000;
   localparam logic [7:0] PIM_SUB_COUNT = 8'h00;
   localparam logic [7:0] PIM_SUB_1 = 8'h01;
   localparam logic [7:0] PIM_SUB_2 = 8'h02;
   localparam logic [7:0] PIM_OUT_MAP_CNT = 8'h02;
   localparam logic [7:0] PIM_IN_MAP_CNT = 8'h02;
   localparam logic [7:0] PIM_ST_MAP_CNT = 8'h01;
   localparam logic [7:0] PIM_DIN_CNT = 8'h02;
   localparam logic [7:0] PIM_FLT_CNT = 8'h01;
   localparam logic [7:0] PIM_DOUT_CNT = 8'h02;
   localparam logic [7:0] PIM_LEN_BYTE = 8'h08;
   localparam logic [7:0] PIM_LEN_WORD = 8'h20;
   localparam int PIM_FLT_OUT_SHORT = 0;
   localparam int PIM_FLT_OUT_SURGE = 1;
   localparam int PIM_FLT_ACT_SHORT = 2;
   localparam int PIM_FLT_ACT_UNDER = 3;
   localparam int PIM_FLT_SNS_SURGE = 4;
   localparam int PIM_FLT_SNS_UNDER = 5;
   localparam int PIM_FLT_W = 6;
   localparam int PIM_CHANNELS = 16;
   localparam int PIM_FIFO_DEPTH = 4;
   localparam logic [15:0] PIM_DOUT_RST = 16'h0000;
   localparam logic [31:0] PIM_WORD_RST = 32'h0000_0000;
   typedef struct packed {
      logic [15:0] index;
      logic [7:0] sub;
      logic [7:0] len;
   } pim_map_entry_s;
   typedef struct packed {
      logic [31:0] status;
      logic [15:0] inputs;
   } pim_in_image_s;
endpackage : pim_pkg

// *** verilog/pim_fifo.sv ***
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module pim_fifo #(
   parameter int W = 16,
   parameter int D = 4
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   localparam logic [AW:0] FULL_CNT = (AW+1)'(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic [AW:0] next_count;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
   assign out_data = mem[rd_ptr];
   // flags are registered so the top sees clean, flop-driven handshakes
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         count <= '0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         count <= next_count;
         in_ready <= next_count != FULL_CNT;
         out_valid <= next_count != '0;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule : pim_fifo

// *** verilog/pim_process_image.sv ***
// cyclic process image and mapping objects of a 16-channel digital i/o slave
// Overview of operation
// - mapping entry: index in 31..16, subindex in 15..8, bit length in 7..0
// - output map reports 2 entries: 0x5000 sub 1 then sub 2, 8 bits each
// - input map reports 2 entries: 0x4000 sub 1 then sub 2, 8 bits each
// - status map reports 1 entry: 0x4001 sub 1, 32 bits
// - input byte 0 holds inputs 1..8, input 1 in bit 0
// - input byte 1 holds inputs 9..16, input 9 in bit 0
// - status bits 0..2: output short, output surge, actuator supply short
// - status bits 3..5: actuator under, sensor surge, sensor under; 31..16 reserved
// - output byte 0 from master drives outputs 1..8, output 1 from bit 0
// - output byte 1 from master drives outputs 9..16, output 9 from bit 0
// - every input image carries the four-byte status word
`timescale 1ns/1ps
module pim_process_image
   import pim_pkg::*;
#(
   parameter int CH = PIM_CHANNELS,
   parameter int DEPTH = PIM_FIFO_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [CH-1:0] digital_input_channel,
   input wire logic [PIM_FLT_W-1:0] fault_in,
   input wire logic od_rd,
   input wire logic od_wr,
   input wire logic [15:0] od_index,
   input wire logic [7:0] od_sub,
   output logic od_ack,
   output logic od_err,
   output logic [31:0] od_rdata,
   input wire logic img_req,
   output logic img_valid,
   output pim_in_image_s img_data,
   input wire logic out_valid,
   output logic out_ready,
   input wire logic [CH-1:0] out_data,
   input wire logic out_apply,
   output logic [CH-1:0] digital_output
);
   localparam pim_map_entry_s OUT_E1 = '{PIM_IDX_DOUT, PIM_SUB_1, PIM_LEN_BYTE};
   localparam pim_map_entry_s OUT_E2 = '{PIM_IDX_DOUT, PIM_SUB_2, PIM_LEN_BYTE};
   localparam pim_map_entry_s IN_E1 = '{PIM_IDX_DIN, PIM_SUB_1, PIM_LEN_BYTE};
   localparam pim_map_entry_s IN_E2 = '{PIM_IDX_DIN, PIM_SUB_2, PIM_LEN_BYTE};
   localparam pim_map_entry_s ST_E1 = '{PIM_IDX_FLT, PIM_SUB_1, PIM_LEN_WORD};

   logic [CH-1:0] din_q;
   logic [PIM_FLT_W-1:0] flt_q;
   logic [31:0] status_word;
   logic fifo_valid;
   logic [CH-1:0] fifo_data;
   logic [31:0] rd_val;
   logic rd_hit;

   // input sampling; pins are taken as synchronous
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         din_q <= '0;
         flt_q <= '0;
      end else begin
         din_q <= digital_input_channel;
         flt_q <= fault_in;
      end
   end

   // undefined status bits tied low
   assign status_word = {26'h0, flt_q};

   // input image: one cycle after a request, inputs plus status word
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         img_valid <= 1'b0;
         img_data <= '0;
      end else begin
         img_valid <= img_req;
         if (img_req) begin
            img_data.inputs <= din_q;
            img_data.status <= status_word;
         end
      end
   end

   // output image path; the fifo stalls while out_apply is low
   wire fifo_pop = fifo_valid & out_apply;

   pim_fifo #(
      .W(CH),
      .D(DEPTH)
   ) u_out_fifo (
      .ref_clk(ref_clk),
      .rst(rst),
      .in_valid(out_valid),
      .in_ready(out_ready),
      .in_data(out_data),
      .out_valid(fifo_valid),
      .out_ready(out_apply),
      .out_data(fifo_data)
   );

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         digital_output <= PIM_DOUT_RST;
      end else if (fifo_pop) begin
         digital_output <= fifo_data;
      end
   end

   // object dictionary decode
   wire sel_om = od_index == PIM_IDX_OUT_MAP;
   wire sel_im = od_index == PIM_IDX_IN_MAP;
   wire sel_sm = od_index == PIM_IDX_ST_MAP;
   wire sel_din = od_index == PIM_IDX_DIN;
   wire sel_flt = od_index == PIM_IDX_FLT;
   wire sel_dout = od_index == PIM_IDX_DOUT;
   wire s0 = od_sub == PIM_SUB_COUNT;
   wire s1 = od_sub == PIM_SUB_1;
   wire s2 = od_sub == PIM_SUB_2;
   wire two_sub = sel_om | sel_im | sel_din | sel_dout;
   wire one_sub = sel_sm | sel_flt;

   assign rd_hit = (two_sub & (s0 | s1 | s2)) | (one_sub & (s0 | s1));

   wire [31:0] om_val = s0 ? {24'h0, PIM_OUT_MAP_CNT} : s1 ? OUT_E1 : OUT_E2;
   wire [31:0] im_val = s0 ? {24'h0, PIM_IN_MAP_CNT} : s1 ? IN_E1 : IN_E2;
   wire [31:0] sm_val = s0 ? {24'h0, PIM_ST_MAP_CNT} : ST_E1;
   wire [31:0] din_val = s0 ? {24'h0, PIM_DIN_CNT}
                        : s1 ? {24'h0, din_q[7:0]} : {24'h0, din_q[15:8]};
   wire [31:0] flt_val = s0 ? {24'h0, PIM_FLT_CNT} : status_word;
   wire [31:0] dout_val = s0 ? {24'h0, PIM_DOUT_CNT}
                         : s1 ? {24'h0, digital_output[7:0]}
                         : {24'h0, digital_output[15:8]};

   assign rd_val = sel_om ? om_val
                 : sel_im ? im_val
                 : sel_sm ? sm_val
                 : sel_din ? din_val
                 : sel_flt ? flt_val
                 : dout_val;

   // every object is read-only, so a write only earns an error answer
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         od_ack <= 1'b0;
         od_err <= 1'b0;
         od_rdata <= PIM_WORD_RST;
      end else begin
         od_ack <= od_rd | od_wr;
         od_err <= od_wr | (od_rd & ~rd_hit);
         od_rdata <= (od_rd & ~od_wr & rd_hit) ? rd_val : PIM_WORD_RST;
      end
   end

   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   sequence rd_of(logic [15:0] ix, logic [7:0] sb);
      od_rd && !od_wr && od_index == ix && od_sub == sb;
   endsequence

   sequence req_seq;
      img_req;
   endsequence

   // occupancy counted from the handshakes alone, so a stuck full flag cannot hide
   logic [3:0] held_words;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         held_words <= 4'h0;
      end else begin
         held_words <= held_words + 4'(out_valid & out_ready) - 4'(fifo_pop);
      end
   end

   sequence take_empty;
      out_valid && out_ready && !fifo_valid && out_apply;
   endsequence

   sequence apply_next;
      take_empty ##1 out_apply;
   endsequence

   chk_out_map_entry1: assert property (
      rd_of(PIM_IDX_OUT_MAP, PIM_SUB_1) |=> od_ack && !od_err && od_rdata == 32'h5000_0108)
      else $error("output map entry 1 wrong");

   chk_in_map_entry2: assert property (
      rd_of(PIM_IDX_IN_MAP, PIM_SUB_2) |=> od_ack && od_rdata == 32'h4000_0208)
      else $error("input map entry 2 wrong");

   chk_status_map_entry: assert property (
      rd_of(PIM_IDX_ST_MAP, PIM_SUB_1) |=> od_rdata[31:16] == 16'h4001
      && od_rdata[15:8] == 8'h01 && od_rdata[7:0] == 8'h20)
      else $error("status map entry wrong");

   chk_map_counts: assert property (
      rd_of(PIM_IDX_OUT_MAP, PIM_SUB_COUNT) or rd_of(PIM_IDX_IN_MAP, PIM_SUB_COUNT)
      |=> od_rdata == 32'h0000_0002)
      else $error("map count wrong");

   chk_image_inputs: assert property (
      req_seq |=> img_valid && img_data.inputs[7:0] == $past(digital_input_channel[7:0], 2)
      && img_data.inputs[15:8] == $past(digital_input_channel[15:8], 2))
      else $error("input bytes misplaced");

   chk_image_status: assert property (
      req_seq |=> img_valid && img_data.status[31:PIM_FLT_W] == '0
      && img_data.status[PIM_FLT_W-1:0] == $past(fault_in, 2))
      else $error("status word wrong");

   chk_fault_read: assert property (
      rd_of(PIM_IDX_FLT, PIM_SUB_1) |=> od_rdata == {26'h0, $past(fault_in, 2)})
      else $error("status read wrong");

   chk_write_refused: assert property (
      od_wr |=> od_ack && od_err && od_rdata == 32'h0)
      else $error("write not refused");

   chk_output_apply: assert property (
      fifo_pop |=> digital_output == $past(fifo_data))
      else $error("output byte not applied");

   chk_output_hold: assert property (
      !out_apply |=> $stable(digital_output))
      else $error("outputs moved while held");

   chk_image_single: assert property (
      !img_req |=> !img_valid)
      else $error("spurious image");

   chk_out_map_entry2: assert property (
      rd_of(PIM_IDX_OUT_MAP, PIM_SUB_2) |=> od_ack && !od_err && od_rdata == 32'h5000_0208)
      else $error("output map entry 2 wrong");

   chk_in_map_entry1: assert property (
      rd_of(PIM_IDX_IN_MAP, PIM_SUB_1) |=> od_ack && !od_err && od_rdata == 32'h4000_0108)
      else $error("input map entry 1 wrong");

   chk_status_map_count: assert property (
      rd_of(PIM_IDX_ST_MAP, PIM_SUB_COUNT) |=> !od_err && od_rdata == 32'h0000_0001)
      else $error("status map count wrong");

   chk_status_map_sub2: assert property (
      rd_of(PIM_IDX_ST_MAP, PIM_SUB_2) |=> od_ack && od_err && od_rdata == 32'h0)
      else $error("status map answered a second entry");

   chk_object_counts: assert property (
      rd_of(PIM_IDX_DIN, PIM_SUB_COUNT) or rd_of(PIM_IDX_DOUT, PIM_SUB_COUNT)
      |=> !od_err && od_rdata == 32'h0000_0002)
      else $error("data object count wrong");

   chk_fault_count: assert property (
      rd_of(PIM_IDX_FLT, PIM_SUB_COUNT) |=> !od_err && od_rdata == 32'h0000_0001)
      else $error("status object count wrong");

   chk_input_byte0: assert property (
      rd_of(PIM_IDX_DIN, PIM_SUB_1)
      |=> od_rdata == {24'h0, $past(digital_input_channel[7:0], 2)})
      else $error("input byte 0 wrong");

   chk_input_byte1: assert property (
      rd_of(PIM_IDX_DIN, PIM_SUB_2)
      |=> od_rdata == {24'h0, $past(digital_input_channel[15:8], 2)})
      else $error("input byte 1 wrong");

   chk_output_byte0: assert property (
      rd_of(PIM_IDX_DOUT, PIM_SUB_1) |=> od_rdata == {24'h0, $past(digital_output[7:0])})
      else $error("output byte 0 readback wrong");

   chk_output_byte1: assert property (
      rd_of(PIM_IDX_DOUT, PIM_SUB_2) |=> od_rdata == {24'h0, $past(digital_output[15:8])})
      else $error("output byte 1 readback wrong");

   chk_fault_low_bits: assert property (
      rd_of(PIM_IDX_FLT, PIM_SUB_1)
      |=> od_rdata[PIM_FLT_ACT_SHORT:PIM_FLT_OUT_SHORT] == $past(fault_in[2:0], 2))
      else $error("output fault bits misplaced");

   chk_status_reserved: assert property (
      img_valid |-> img_data.status[31:16] == 16'h0)
      else $error("reserved status bits set");

   chk_status_spare: assert property (
      img_valid |-> img_data.status[15:PIM_FLT_W] == '0)
      else $error("undefined status bits set");

   chk_unmapped_sub: assert property (
      od_rd && !od_wr && od_sub > PIM_SUB_2 |=> od_ack && od_err && od_rdata == 32'h0)
      else $error("unmapped subindex answered");

   chk_answer_idle: assert property (
      !od_rd && !od_wr |=> !od_ack && !od_err && od_rdata == 32'h0)
      else $error("answer without request");

   chk_ack_answer: assert property (
      od_rd || od_wr |=> od_ack)
      else $error("request not acknowledged");

   chk_write_wins: assert property (
      od_rd && od_wr |=> od_err && od_rdata == 32'h0)
      else $error("read with write not refused");

   chk_image_holds: assert property (
      !img_req |=> $stable(img_data))
      else $error("image changed without request");

   chk_apply_latency: assert property (
      apply_next |=> digital_output == $past(out_data, 2))
      else $error("output word late or wrong");

   chk_ready_full: assert property (
      held_words == 4'(DEPTH) |-> !out_ready)
      else $error("fifo accepts while full");
endmodule : pim_process_image

// *** sim/pim_master_model.sv ***
// master side model that offers output image words over valid/ready
`timescale 1ns/1ps
module pim_master_model (
   input wire logic ref_clk,
   input wire logic out_ready,
   output logic out_valid,
   output logic [15:0] out_data
);
   logic [15:0] last_word = 16'h0000;
   initial begin
      out_valid = 1'b0;
      out_data = 16'hFFFF;
   end
   // entered just after an edge; gap 0 keeps valid up for back-to-back words
   task automatic send(input logic [15:0] word, input int gap);
      if (gap > 0) begin
         idle();
         repeat (gap) @(posedge ref_clk);
         #1;
      end
      out_valid = 1'b1;
      out_data = word;
      @(posedge ref_clk iff out_ready === 1'b1);
      #1;
      last_word = word;
   endtask : send
   // a released bus shows the inverse, never a stale word
   task automatic idle();
      out_valid = 1'b0;
      out_data = ~last_word;
   endtask : idle
endmodule : pim_master_model

// *** sim/pim_process_image_tb.sv ***
// self-checking bench for the process image block
`timescale 1ns/1ps
module pim_process_image_tb;
   import pim_pkg::*;
   logic ref_clk, rst, od_rd, od_wr, od_ack, od_err, img_req, img_valid;
   logic out_valid, out_ready, out_apply;
   logic [15:0] pins, od_index, out_data, digital_output, w, last_push;
   logic [15:0] applied = 16'h0000;
   logic [5:0] fault;
   logic [7:0] od_sub;
   logic [31:0] od_rdata, tmp;
   logic [31:0] seed = 32'h0000_D61A;
   pim_in_image_s img_data;
   logic [15:0] exp_q[$];
   int miscompares = 0;
   int total_checks = 0;
   logic [23:0] probes [20] = '{24'h1600_00, 24'h1600_01, 24'h1600_02, 24'h1600_03,
      24'h1A00_00, 24'h1A00_01, 24'h1A00_02, 24'h1A01_00, 24'h1A01_01, 24'h1A01_02,
      24'h4000_00, 24'h4000_01, 24'h4000_02, 24'h4001_00, 24'h4001_01, 24'h5000_00,
      24'h5000_01, 24'h5000_02, 24'h7777_00, 24'h4002_01};
   pim_process_image u_pim_process_image (.ref_clk(ref_clk), .rst(rst),
      .digital_input_channel(pins), .fault_in(fault), .od_rd(od_rd), .od_wr(od_wr),
      .od_index(od_index), .od_sub(od_sub), .od_ack(od_ack), .od_err(od_err),
      .od_rdata(od_rdata), .img_req(img_req), .img_valid(img_valid), .img_data(img_data),
      .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
      .out_apply(out_apply), .digital_output(digital_output));
   pim_master_model u_pim_master_model (.ref_clk(ref_clk), .out_ready(out_ready),
      .out_valid(out_valid), .out_data(out_data));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // {err, data} that an object read must answer with
   function automatic logic [32:0] exp_od(input logic [23:0] p);
      case (p)
         24'h1600_00, 24'h1A00_00, 24'h4000_00, 24'h5000_00: return 33'h0_0000_0002;
         24'h1A01_00, 24'h4001_00: return 33'h0_0000_0001;
         24'h1600_01: return 33'h0_5000_0108;
         24'h1600_02: return 33'h0_5000_0208;
         24'h1A00_01: return 33'h0_4000_0108;
         24'h1A00_02: return 33'h0_4000_0208;
         24'h1A01_01: return 33'h0_4001_0120;
         24'h4000_01: return {25'h0, pins[7:0]};
         24'h4000_02: return {25'h0, pins[15:8]};
         24'h4001_01: return {27'h0, fault};
         24'h5000_01: return {25'h0, applied[7:0]};
         24'h5000_02: return {25'h0, applied[15:8]};
         default: return {1'b1, 32'h0};
      endcase
   endfunction : exp_od
   task automatic chk(input string name, input logic [47:0] e, input logic [47:0] g);
      total_checks++;
      if (e !== g) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", name, e, g);
      end
   endtask : chk
   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask : tick
   // od_rd/od_wr are left up so accesses run back to back
   task automatic od_access(input logic wr, input logic [23:0] p);
      logic [32:0] e;
      e = wr ? {1'b1, 32'h0} : exp_od(p);
      od_rd = !wr;
      od_wr = wr;
      {od_index, od_sub} = p;
      tick();
      chk("od_ack", 48'h1, {47'h0, od_ack});
      chk("od_answer", {15'h0, e}, {15'h0, od_err, od_rdata});
   endtask : od_access
   task automatic push(input int gap);
      tmp = rnd();
      w = (tmp[15:0] == last_push) ? ~tmp[15:0] : tmp[15:0];
      last_push = w;
      exp_q.push_back(w);
      u_pim_master_model.send(w, gap);
   endtask : push
   task automatic drain();
      for (int n = 0; n < 40 && exp_q.size() > 0; n++) tick();
      tick();
      chk("drained", 48'h0, {16'h0, exp_q.size()});
   endtask : drain
   task automatic summarize();
      $display("checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : summarize
   // each applied word must be the next queued one, in order
   always @(posedge ref_clk) begin
      #2;
      if (rst === 1'b0 && digital_output !== applied) begin
         applied = (exp_q.size() > 0) ? exp_q.pop_front() : ~digital_output;
         chk("digital_output", {32'h0, applied}, {32'h0, digital_output});
         applied = digital_output;
      end
   end
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial begin
      #(50 * 4000);
      miscompares++;
      summarize();
   end
   initial begin
      {rst, pins, fault, od_rd, od_wr, od_index, od_sub, img_req} = {1'b1, 49'h0};
      {out_apply, last_push} = {1'b1, 16'h0000};
      repeat (3) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      for (int r = 0; r < 3; r++) begin
         tmp = rnd();
         pins = (r == 0) ? 16'h8001 : tmp[15:0];
         fault = (r == 0) ? 6'h3F : tmp[21:16];
         tick();
         tick();
         foreach (probes[i]) od_access(1'b0, probes[i]);
         od_access(1'b1, 24'h1600_01);
         {od_rd, od_wr} = 2'b11;
         tick();
         chk("od_both", {15'h0, 1'b1, 32'h0}, {15'h0, od_err, od_rdata});
         od_access(1'b0, 24'h1600_01);
         {od_rd, od_wr, img_req} = 3'b001;
         tick();
         img_req = 1'b0;
         chk("img_valid", 48'h1, {47'h0, img_valid});
         chk("img_data", {26'h0, fault, pins}, img_data);
         tick();
         chk("od_ack_idle", 48'h0, {47'h0, od_ack});
      end
      $display("test mapping and image done");
      for (int k = 0; k < 8; k++) push(k % 3);
      u_pim_master_model.idle();
      drain();
      od_access(1'b0, 24'h5000_01);
      od_access(1'b0, 24'h5000_02);
      od_rd = 1'b0;
      out_apply = 1'b0;
      repeat (4) push(0);
      u_pim_master_model.idle();
      tick();
      chk("out_ready_full", 48'h0, {47'h0, out_ready});
      chk("held_output", {32'h0, applied}, {32'h0, digital_output});
      out_apply = 1'b1;
      push(0);
      u_pim_master_model.idle();
      drain();
      $display("test output stream done");
      summarize();
   end
endmodule : pim_process_image_tb
